// ---- boot_config_script_interpreter.sv ----
`timescale 1ns/1ps
module boot_config_script_interpreter (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic OTP_READY,
   input wire logic UART_BAUD_SET,
   output logic OTP_RD_REQ,
   output logic [5:0] OTP_RD_INDEX,
   input wire logic OTP_RD_VALID,
   input wire logic [31:0] OTP_RD_DATA,
   output logic REG_WR_REQ,
   output logic [31:0] REG_WR_ADDR,
   output logic [31:0] REG_WR_DATA,
   input wire logic REG_WR_ACK,
   output logic DEBUG_LOCKOUT,
   output logic [27:0] UART_RECEIVE_START_TIMEOUT,
   output logic SPI_BOOT_FAST_CLK,
   output logic SCRIPT_VALID,
   output logic BUSY,
   output logic DONE
);
   // ==========================================
   // state
   typedef enum logic [2:0] {
      IDLE, READ, WAIT_WORD, WRITE_REG, FINISH
   } state_t;

   typedef enum logic [1:0] {
      EXPECT_MARKER, EXPECT_CMD, EXPECT_DATA, EXPECT_SKIP
   } phase_t;

   state_t state;
   state_t next_state;
   phase_t phase;
   logic [5:0] index;
   logic [7:0] skip_left;
   logic [31:0] wr_addr;
   logic [31:0] word;
   logic is_empty;
   logic is_debug_lock;
   logic is_spi_fast;
   logic is_cal_header;
   logic is_uart_timeout;
   logic [7:0] cal_count;
   logic last_word;
   logic word_in;
   logic stop_now;
   logic is_command;
   logic take_addr;
   logic take_data;
   logic take_setting;
   logic advance;

   assign word = OTP_RD_DATA;
   assign word_in = (state == WAIT_WORD) && OTP_RD_VALID;
   assign last_word = (index == cfg_script_pkg::LAST_INDEX);

   // ==========================================
   // word classification
   // anything that is neither a known command word nor an erased word is a register address
   assign is_command = is_cal_header || is_debug_lock || is_spi_fast || is_uart_timeout;
   assign take_setting = word_in && (phase == EXPECT_CMD) && !is_empty;
   assign take_addr = take_setting && !is_command;
   assign take_data = word_in && (phase == EXPECT_DATA);

   cfg_word_decode u_decode (
      .word(word),
      .is_empty(is_empty),
      .is_debug_lock(is_debug_lock),
      .is_spi_fast(is_spi_fast),
      .is_cal_header(is_cal_header),
      .is_uart_timeout(is_uart_timeout),
      .cal_count(cal_count)
   );

   // ==========================================
   // termination of the walk
   always_comb begin
      stop_now = 1'b0;
      case (phase)
         EXPECT_MARKER: begin
            stop_now = (word != cfg_script_pkg::START_MARKER);
         end
         EXPECT_CMD: begin
            // an erased word inside a pair or a skipped record is plain data
            stop_now = is_empty;
         end
         default: begin
            stop_now = 1'b0;
         end
      endcase
   end

   // ==========================================
   // sequencer
   always_comb begin
      next_state = state;
      case (state)
         IDLE: begin
            if (OTP_READY && UART_BAUD_SET) begin
               next_state = READ;
            end
         end
         READ: begin
            next_state = WAIT_WORD;
         end
         WAIT_WORD: begin
            if (OTP_RD_VALID) begin
               if (stop_now) begin
                  next_state = FINISH;
               end else if (phase == EXPECT_DATA) begin
                  next_state = WRITE_REG;
               end else if (last_word) begin
                  next_state = FINISH;
               end else begin
                  next_state = READ;
               end
            end
         end
         WRITE_REG: begin
            // writes complete before the next read, keeping storage order
            if (REG_WR_ACK) begin
               next_state = last_word ? FINISH : READ;
            end
         end
         FINISH: begin
            next_state = FINISH;
         end
         default: begin
            next_state = IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state <= IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================
   // word index, advanced after each consumed word except the one at LAST_INDEX, where it holds
   always_comb begin
      advance = 1'b0;
      if (!last_word) begin
         if (word_in && !stop_now && (phase != EXPECT_DATA)) begin
            advance = 1'b1;
         end else if ((state == WRITE_REG) && REG_WR_ACK) begin
            // a data word is only passed once its write has been taken
            advance = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         index <= cfg_script_pkg::INDEX_RESET;
      end else if (advance) begin
         index <= index + 6'h01;
      end
   end

   // ==========================================
   // decode phase
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         phase <= EXPECT_MARKER;
      end else if (word_in && !stop_now) begin
         case (phase)
            EXPECT_MARKER: begin
               phase <= EXPECT_CMD;
            end
            EXPECT_CMD: begin
               if (is_cal_header) begin
                  // the index byte is opaque here; only the count matters
                  if (cal_count != 8'h00) begin
                     phase <= EXPECT_SKIP;
                  end
               end else if (!is_command) begin
                  phase <= EXPECT_DATA;
               end
            end
            EXPECT_SKIP: begin
               if (skip_left == 8'h01) begin
                  phase <= EXPECT_CMD;
               end
            end
            EXPECT_DATA: begin
               phase <= EXPECT_CMD;
            end
            default: begin
               phase <= EXPECT_CMD;
            end
         endcase
      end
   end

   // ==========================================
   // calibration words still to be passed over
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         skip_left <= 8'h00;
      end else if (word_in && (phase == EXPECT_CMD) && is_cal_header) begin
         skip_left <= cal_count;
      end else if (word_in && (phase == EXPECT_SKIP)) begin
         skip_left <= skip_left - 8'h01;
      end
   end

   // ==========================================
   // address word held until its data word arrives
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wr_addr <= 32'h00000000;
      end else if (take_addr) begin
         wr_addr <= word;
      end
   end

   // ==========================================
   // register write port, steady until the write is acknowledged
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         REG_WR_ADDR <= 32'h00000000;
         REG_WR_DATA <= 32'h00000000;
      end else if (take_data) begin
         REG_WR_ADDR <= wr_addr;
         REG_WR_DATA <= word;
      end
   end

   // ==========================================
   // boot settings picked up from the script
   // sticky: a later entry cannot undo the lockout
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         DEBUG_LOCKOUT <= 1'b0;
      end else if (take_setting && is_debug_lock) begin
         DEBUG_LOCKOUT <= 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         UART_RECEIVE_START_TIMEOUT <= cfg_script_pkg::UART_TIMEOUT_RESET;
      end else if (take_setting && is_uart_timeout) begin
         // a later timeout entry simply replaces an earlier one
         UART_RECEIVE_START_TIMEOUT <= word[27:0];
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         SPI_BOOT_FAST_CLK <= 1'b0;
      end else if (take_setting && is_spi_fast) begin
         SPI_BOOT_FAST_CLK <= 1'b1;
      end
   end

   // ==========================================
   // status
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         SCRIPT_VALID <= 1'b0;
      end else if (word_in && phase == EXPECT_MARKER &&
                   word == cfg_script_pkg::START_MARKER) begin
         SCRIPT_VALID <= 1'b1;
      end
   end

   // ==========================================
   // busy and done, taken from next_state so they move with state
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= (next_state != IDLE) && (next_state != FINISH);
      end
   end

   // done holds until reset and stands for the release of the processor
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         DONE <= 1'b0;
      end else begin
         DONE <= (next_state == FINISH);
      end
   end

   // ==========================================
   // read and write requests
   assign OTP_RD_REQ = (state == READ);
   assign OTP_RD_INDEX = index;
   assign REG_WR_REQ = (state == WRITE_REG);
endmodule

// ---- boot_config_script_interpreter_bench.sv ----
`timescale 1ns/1ps
// ========================================
// random script runs
module boot_config_script_interpreter_bench;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic OTP_READY = 1'b0;
   logic UART_BAUD_SET = 1'b0;
   logic OTP_RD_REQ, OTP_RD_VALID, REG_WR_REQ, REG_WR_ACK, DEBUG_LOCKOUT, lk, fs;
   logic SPI_BOOT_FAST_CLK, SCRIPT_VALID, BUSY, DONE;
   logic [5:0] OTP_RD_INDEX;
   logic [27:0] UART_RECEIVE_START_TIMEOUT, tm;
   logic [31:0] OTP_RD_DATA, REG_WR_ADDR, REG_WR_DATA;
   logic [31:0] s [60];
   logic [31:0] ea [60];
   logic [31:0] ed [60];
   int ne, nw, cyc;
   int n_fail = 0;
   int checked = 0;
   always #5 CLK = ~CLK;
   boot_config_script_interpreter u_boot_config_script_interpreter (.CLK(CLK), .RESET(RESET),
      .OTP_READY(OTP_READY), .UART_BAUD_SET(UART_BAUD_SET), .OTP_RD_REQ(OTP_RD_REQ),
      .OTP_RD_INDEX(OTP_RD_INDEX), .OTP_RD_VALID(OTP_RD_VALID), .OTP_RD_DATA(OTP_RD_DATA),
      .REG_WR_REQ(REG_WR_REQ), .REG_WR_ADDR(REG_WR_ADDR), .REG_WR_DATA(REG_WR_DATA),
      .REG_WR_ACK(REG_WR_ACK), .DEBUG_LOCKOUT(DEBUG_LOCKOUT),
      .UART_RECEIVE_START_TIMEOUT(UART_RECEIVE_START_TIMEOUT),
      .SPI_BOOT_FAST_CLK(SPI_BOOT_FAST_CLK), .SCRIPT_VALID(SCRIPT_VALID), .BUSY(BUSY),
      .DONE(DONE));
   otp_reg_model u_otp_reg_model (.CLK(CLK), .rd_req(OTP_RD_REQ), .idx(OTP_RD_INDEX),
      .rd_valid(OTP_RD_VALID), .rd_data(OTP_RD_DATA), .wr_req(REG_WR_REQ), .wr_ack(REG_WR_ACK));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
      if (!RESET && REG_WR_REQ === 1'b1 && REG_WR_ACK === 1'b1) begin
         chk(REG_WR_ADDR, ea[nw]);
         chk(REG_WR_DATA, ed[nw]);
         nw++;
      end
   end
   function automatic void predict();
      int i = 1;
      ne = 0;
      lk = 1'b0;
      fs = 1'b0;
      tm = 28'h0;
      while (s[0] == cfg_script_pkg::START_MARKER && i < 60) begin
         if (s[i] == 32'h0fffffff || s[i] == 32'hffffffff) break;
         if (s[i][31:16] == 16'h9000) i += s[i][15:8];
         else if (s[i] == 32'h70000000) lk = 1'b1;
         else if (s[i][31:28] == 4'h8) tm = s[i][27:0];
         else if (s[i] == 32'ha0000000) fs = 1'b1;
         else begin
            // a pair cut at the last word is dropped
            ea[ne] = s[i];
            ed[ne] = s[i + 1];
            if (i < 59) ne++;
            i++;
         end
         i++;
      end
   endfunction
   task automatic run(input int r);
      int i, k;
      s[0] = (r == 0) ? {4'h3, 28'($urandom)} : cfg_script_pkg::START_MARKER;
      for (i = 1; i < 60; i++) begin
         case ($urandom % 8)
            0: s[i] = {4'h8, 28'($urandom)};
            1: s[i] = 32'h70000000;
            2: s[i] = 32'ha0000000;
            3: s[i] = {16'h9000, 8'($urandom % 4), 8'(i)};
            default: s[i] = {4'h2, 28'($urandom)};
         endcase
      end
      if (r > 1) begin
         k = 4 + $urandom % 50;
         for (i = k - 3; i < k; i++) if (s[i][31:16] == 16'h9000) s[i] = 32'h70000000;
         s[k] = r[0] ? 32'h0fffffff : 32'hffffffff;
      end
      if (r == 8) begin
         // hand-made: timeout, one pair, a three-word record, lockout, erased end
         s[1] = 32'h80000028;
         s[2] = 32'h20000010;
         s[3] = 32'h12345678;
         s[4] = 32'h90000301;
         s[8] = 32'h70000000;
         s[9] = 32'h0fffffff;
      end
      predict();
      for (i = 0; i < 60; i++) u_otp_reg_model.mem[i] = s[i];
      RESET = 1'b1;
      OTP_READY = 1'b0;
      UART_BAUD_SET = 1'b0;
      nw = 0;
      repeat (4) @(negedge CLK);
      RESET = 1'b0;
      OTP_READY = 1'b1;
      repeat (3) @(negedge CLK);
      chk(BUSY, 32'h0);
      UART_BAUD_SET = 1'b1;
      for (k = 0; k < 2000 && DONE !== 1'b1; k++) @(negedge CLK);
      chk(DONE, 32'h1);
      chk(BUSY, 32'h0);
      if (r == 8) chk(32'(nw), 32'h1);
      if (r == 8) chk(UART_RECEIVE_START_TIMEOUT, 32'h28);
      chk(32'(nw), 32'(ne));
      chk(SCRIPT_VALID, 32'(r != 0));
      chk(DEBUG_LOCKOUT, lk);
      chk(UART_RECEIVE_START_TIMEOUT, tm);
      chk(SPI_BOOT_FAST_CLK, fs);
   endtask
   initial begin
      void'($urandom(32'h04b229c1));
      @(negedge CLK);
      for (int r = 0; r < 9; r++) run(r);
      close_out();
   end
endmodule

// ---- boot_config_script_interpreter_chk.sv ----
`timescale 1ns/1ps
// ========================================
// port checker
module boot_config_script_interpreter_chk (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic OTP_READY,
   input wire logic UART_BAUD_SET,
   input wire logic OTP_RD_REQ,
   input wire logic [5:0] OTP_RD_INDEX,
   input wire logic REG_WR_REQ,
   input wire logic [31:0] REG_WR_ADDR,
   input wire logic [31:0] REG_WR_DATA,
   input wire logic REG_WR_ACK,
   input wire logic DEBUG_LOCKOUT,
   input wire logic [27:0] UART_RECEIVE_START_TIMEOUT,
   input wire logic SPI_BOOT_FAST_CLK,
   input wire logic SCRIPT_VALID,
   input wire logic BUSY,
   input wire logic DONE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   a_index_bound: assert property (OTP_RD_REQ |-> OTP_RD_INDEX <= 6'h3b)
      else $error("read index past end");
   a_marker_first: assert property (OTP_RD_REQ && !SCRIPT_VALID |-> OTP_RD_INDEX == 6'h0)
      else $error("read before marker seen");
   a_start_gate: assert property (!BUSY && !DONE && !(OTP_READY && UART_BAUD_SET)
      |=> !OTP_RD_REQ) else $error("walk started early");
   a_wr_hold: assert property (REG_WR_REQ && !REG_WR_ACK |=> REG_WR_REQ
      && $stable(REG_WR_ADDR) && $stable(REG_WR_DATA)) else $error("write moved");
   a_wr_release: assert property (REG_WR_REQ && REG_WR_ACK |=> !REG_WR_REQ)
      else $error("write held after ack");
   a_serial_order: assert property (!(REG_WR_REQ && OTP_RD_REQ))
      else $error("read during write");
   a_index_steady: assert property (REG_WR_REQ && !REG_WR_ACK |=> $stable(OTP_RD_INDEX))
      else $error("index moved during write");
   a_done_quiet: assert property (DONE |-> !REG_WR_REQ && !OTP_RD_REQ ##1 DONE)
      else $error("activity after done");
   a_invalid_default: assert property (DONE && !SCRIPT_VALID |-> !DEBUG_LOCKOUT
      && !SPI_BOOT_FAST_CLK && UART_RECEIVE_START_TIMEOUT == 28'h0) else $error("defaults lost");
   a_sticky_cfg: assert property (!$fell(DEBUG_LOCKOUT) && !$fell(SPI_BOOT_FAST_CLK))
      else $error("setting cleared");
endmodule
bind boot_config_script_interpreter boot_config_script_interpreter_chk u_chk (.CLK(CLK),
   .RESET(RESET), .OTP_READY(OTP_READY), .UART_BAUD_SET(UART_BAUD_SET),
   .OTP_RD_REQ(OTP_RD_REQ), .OTP_RD_INDEX(OTP_RD_INDEX), .REG_WR_REQ(REG_WR_REQ),
   .REG_WR_ADDR(REG_WR_ADDR), .REG_WR_DATA(REG_WR_DATA), .REG_WR_ACK(REG_WR_ACK),
   .DEBUG_LOCKOUT(DEBUG_LOCKOUT), .UART_RECEIVE_START_TIMEOUT(UART_RECEIVE_START_TIMEOUT),
   .SPI_BOOT_FAST_CLK(SPI_BOOT_FAST_CLK), .SCRIPT_VALID(SCRIPT_VALID), .BUSY(BUSY),
   .DONE(DONE));

// ---- cfg_script_pkg.sv ----
package cfg_script_pkg;
   // ==========================================
   // script geometry
   localparam int unsigned SCRIPT_DEPTH = 60;
   localparam int unsigned SCRIPT_BYTES = 240;
   localparam int unsigned IDX_W = 6;
   localparam logic [5:0] LAST_INDEX = 6'h3b;
   localparam logic [5:0] INDEX_RESET = 6'h00;
   // ==========================================
   // command words
   localparam logic [31:0] START_MARKER = 32'ha5a5a5a5;
   localparam logic [31:0] EMPTY_WORD = 32'h0fffffff;
   localparam logic [31:0] EMPTY_WORD_FULL = 32'hffffffff;
   localparam logic [31:0] DEBUG_LOCK_WORD = 32'h70000000;
   localparam logic [31:0] SPI_FAST_WORD = 32'ha0000000;
   localparam logic [15:0] CAL_HEADER_TOP = 16'h9000;
   localparam logic [3:0] UART_TIMEOUT_NIBBLE = 4'h8;
   localparam int unsigned CAL_COUNT_LSB = 8;
   // ==========================================
   // defaults after reset
   localparam logic [27:0] UART_TIMEOUT_RESET = 28'h0000000;
   localparam int unsigned TIMEOUT_UNIT_US = 100;
   localparam int unsigned SPI_SLOW_MHZ = 2;
   localparam int unsigned SPI_FAST_MHZ = 32;
endpackage

// ---- cfg_word_decode.sv ----
`timescale 1ns/1ps
module cfg_word_decode (
   input wire logic [31:0] word,
   output logic is_empty,
   output logic is_debug_lock,
   output logic is_spi_fast,
   output logic is_cal_header,
   output logic is_uart_timeout,
   output logic [7:0] cal_count
);
   // ==========================================
   // pure classification of one script word
   // both the 28-bit and full 32-bit erased patterns end the script where a command word is expected
   assign is_empty = (word == cfg_script_pkg::EMPTY_WORD) ||
                     (word == cfg_script_pkg::EMPTY_WORD_FULL);
   assign is_debug_lock = (word == cfg_script_pkg::DEBUG_LOCK_WORD);
   assign is_spi_fast = (word == cfg_script_pkg::SPI_FAST_WORD);
   assign is_cal_header = (word[31:16] == cfg_script_pkg::CAL_HEADER_TOP);
   assign is_uart_timeout = (word[31:28] == cfg_script_pkg::UART_TIMEOUT_NIBBLE);
   assign cal_count = word[15:8];
endmodule

// ---- otp_reg_model.sv ----
`timescale 1ns/1ps
// ========================================
// otp array and register bus model
module otp_reg_model (
   input wire logic CLK,
   input wire logic rd_req,
   input wire logic [5:0] idx,
   output logic rd_valid,
   output logic [31:0] rd_data,
   input wire logic wr_req,
   output logic wr_ack
);
   logic [31:0] mem [60];
   int rc = -1;
   int wc = -1;
   initial rd_valid = 1'b0;
   initial rd_data = 32'h0;
   initial wr_ack = 1'b0;
   always @(negedge CLK) begin
      rd_valid <= 1'b0;
      // idle bus toggles so stale data never looks valid
      rd_data <= ~rd_data;
      if (rd_req === 1'b1) rc <= $urandom % 4;
      else if (rc == 0) begin
         rd_valid <= 1'b1;
         rd_data <= mem[idx];
         rc <= -1;
      end else if (rc > 0) rc <= rc - 1;
      wr_ack <= 1'b0;
      if (wr_req === 1'b1 && wr_ack !== 1'b1) begin
         if (wc < 0) wc <= $urandom % 3;
         else if (wc == 0) wr_ack <= 1'b1;
         else wc <= wc - 1;
      end else wc <= -1;
   end
endmodule
